/* File: rtl/cri_ctrl.sv */
// Reset, interrupt, system-management and stop-clock control of the core
//
// Summary of operation
// - hard reset returns core to initial state
// - maskable request taken only when enabled
// - accepted request runs two locked acknowledges
// - non-maskable edge after four low clocks
// - soft reset like hard, base kept
// - falling management edge enters management mode
// - taken at instruction boundaries only
// - never splits locks, never nests
// - one further edge pends until resume
// - active output low from save to restore
// - stop request halts, drains, issues grant
// - bus request output follows internal request
`timescale 1ns/1ps
`default_nettype none
module cri_ctrl
   import cri_pkg::*;
#(
   parameter int BASE_W = 32
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic hard_reset_in,
   input wire logic soft_reset_in,
   input wire logic maskable_irq_in,
   input wire logic nmi_in,
   input wire logic sysmgmt_irq_n,
   input wire logic clock_halt_req_n,
   input wire logic instr_boundary,
   input wire logic locked_seq,
   input wire logic if_flag,
   input wire logic core_bus_req,
   input wire logic drain_empty,
   input wire logic bus_cycle_done,
   input wire logic resume_instruction,
   input wire logic restore_last,
   input wire logic base_wr,
   input wire logic [BASE_W-1:0] base_wdata,
   output logic core_reset_q,
   output logic mirq_take_q,
   output logic nmi_take_q,
   output logic mgmt_enter_q,
   output logic sysmgmt_mode,
   output logic sysmgmt_active_n,
   output logic cyc_req_q,
   output cri_cyc_t cyc_type_q,
   output logic cyc_lock_q,
   output logic stopped_q,
   output logic bus_request_out,
   output logic [BASE_W-1:0] sysmgmt_base_reg
);
   // ***************************************************
   // Input synchronisation
   // ***************************************************
   cri_sync_if #(.W(CRI_NIN)) sif ();

   assign sif.raw = {clock_halt_req_n, sysmgmt_irq_n, nmi_in,
                     maskable_irq_in, soft_reset_in, hard_reset_in};

   cri_sync #(
      .W(CRI_NIN),
      .STAGES(CRI_SYNC_STAGES),
      .RST_VAL(CRI_SYNC_RST)
   ) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .sif(sif)
   );

   wire hard_s = sif.synced[CRI_LN_HARD];
   wire soft_s = sif.synced[CRI_LN_SOFT];
   wire mirq_s = sif.synced[CRI_LN_MIRQ];
   wire nmi_s = sif.synced[CRI_LN_NMI];
   wire sysm_n_s = sif.synced[CRI_LN_SYSM_N];
   wire halt_n_s = sif.synced[CRI_LN_HALT_N];

   // ***************************************************
   // Edge detection and pending flags
   // ***************************************************
   logic nmi_prev_q, sysm_prev_q;
   logic [2:0] nmi_low_q, nmi_low_d;
   logic nmi_pend_q, sysm_pend_q;
   cri_state_t state_q, state_d;

   wire rst_any = srst | hard_s | soft_s;
   wire nmi_rise = nmi_s & ~nmi_prev_q & (nmi_low_q >= CRI_NMI_LOW_MAX);
   wire sysm_fall = ~sysm_n_s & sysm_prev_q;
   wire at_bound = instr_boundary & ~locked_seq;
   wire idle = (state_q == CRI_IDLE);
   wire go_sysm = idle & at_bound & sysm_pend_q;
   wire go_nmi = idle & at_bound & ~sysm_pend_q & nmi_pend_q;
   wire go_mirq = idle & at_bound & ~sysm_pend_q & ~nmi_pend_q &
                  mirq_s & if_flag;
   wire go_halt = idle & at_bound & ~sysm_pend_q & ~nmi_pend_q &
                  ~(mirq_s & if_flag) & ~halt_n_s;
   wire cyc_done = cyc_req_q & bus_cycle_done;

   assign nmi_low_d = nmi_s ? 3'h0 :
                      (nmi_low_q == CRI_NMI_LOW_MAX) ? nmi_low_q :
                      nmi_low_q + 3'h1;

   always_ff @(posedge core_clk) begin
      if (rst_any) begin
         nmi_prev_q <= 1'b0;
         sysm_prev_q <= 1'b1;
         nmi_low_q <= 3'h0;
         nmi_pend_q <= 1'b0;
         sysm_pend_q <= 1'b0;
      end else begin
         nmi_prev_q <= nmi_s;
         sysm_prev_q <= sysm_n_s;
         nmi_low_q <= nmi_low_d;
         nmi_pend_q <= nmi_rise | (nmi_pend_q & ~go_nmi);
         // A second edge inside the routine waits here until resume
         sysm_pend_q <= sysm_fall | (sysm_pend_q & ~go_sysm);
      end
   end

   // ***************************************************
   // Sequencer
   // ***************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         CRI_IDLE: begin
            if (go_sysm) begin
               state_d = CRI_MGMT;
            end else if (go_mirq) begin
               state_d = CRI_INTA1;
            end else if (go_halt) begin
               state_d = CRI_DRAIN;
            end
         end
         CRI_INTA1: begin
            if (cyc_done) begin
               state_d = CRI_INTA2;
            end
         end
         CRI_INTA2: begin
            if (cyc_done) begin
               state_d = CRI_IDLE;
            end
         end
         CRI_MGMT: begin
            if (resume_instruction & restore_last) begin
               state_d = CRI_IDLE;
            end
         end
         CRI_DRAIN: begin
            if (drain_empty) begin
               state_d = CRI_GRANT;
            end
         end
         CRI_GRANT: begin
            if (cyc_done) begin
               state_d = CRI_STOP;
            end
         end
         CRI_STOP: begin
            if (halt_n_s) begin
               state_d = CRI_IDLE;
            end
         end
         default: begin
            state_d = CRI_IDLE;
         end
      endcase
   end

   wire next_inta = (state_d == CRI_INTA1) | (state_d == CRI_INTA2);
   wire next_grant = (state_d == CRI_GRANT);
   wire next_mgmt = (state_d == CRI_MGMT);
   // A new acknowledge cycle starts after the previous one completes
   wire next_req = (next_inta | next_grant) & ~(cyc_done & ~(state_d !=
                   state_q));

   always_ff @(posedge core_clk) begin
      if (rst_any) begin
         state_q <= CRI_IDLE;
         core_reset_q <= 1'b1;
         mirq_take_q <= 1'b0;
         nmi_take_q <= 1'b0;
         mgmt_enter_q <= 1'b0;
         sysmgmt_mode <= 1'b0;
         sysmgmt_active_n <= 1'b1;
         cyc_req_q <= 1'b0;
         cyc_type_q <= CRI_CYC_NONE;
         cyc_lock_q <= 1'b0;
         stopped_q <= 1'b0;
         bus_request_out <= 1'b0;
      end else begin
         state_q <= state_d;
         core_reset_q <= 1'b0;
         mirq_take_q <= (state_q == CRI_INTA2) & cyc_done;
         nmi_take_q <= go_nmi;
         mgmt_enter_q <= go_sysm;
         sysmgmt_mode <= next_mgmt;
         sysmgmt_active_n <= ~next_mgmt;
         cyc_req_q <= next_req;
         cyc_type_q <= next_inta ? CRI_CYC_INTACK :
                       next_grant ? CRI_CYC_HALTGNT : CRI_CYC_NONE;
         cyc_lock_q <= next_inta;
         stopped_q <= (state_d == CRI_STOP);
         bus_request_out <= core_bus_req | next_req;
      end
   end

   // Base register survives a soft reset
   always_ff @(posedge core_clk) begin
      if (srst | hard_s) begin
         sysmgmt_base_reg <= CRI_BASE_RST[BASE_W-1:0];
      end else if (base_wr & ~soft_s) begin
         sysmgmt_base_reg <= base_wdata;
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   reset_init_a: assert property (@(posedge core_clk)
      (hard_s | soft_s) |=> (core_reset_q && state_q == CRI_IDLE))
      else $error("reset did not return to initial state");

   mirq_mask_a: assert property (
      @(posedge core_clk) disable iff (srst)
      (state_q == CRI_INTA1 && $past(state_q) == CRI_IDLE) |->
      $past(if_flag) && $past(mirq_s))
      else $error("maskable request taken while disabled");

   inta_pair_a: assert property (
      @(posedge core_clk) disable iff (srst)
      mirq_take_q |-> $past(state_q) == CRI_INTA2 && cyc_type_q !=
      CRI_CYC_HALTGNT)
      else $error("acknowledge finished without second cycle");

   nmi_edge_a: assert property (
      @(posedge core_clk) disable iff (rst_any)
      (!nmi_pend_q && !nmi_rise) |=> !nmi_pend_q)
      else $error("non-maskable pending without qualified edge");

   sysm_latch_a: assert property (
      @(posedge core_clk) disable iff (rst_any)
      sysm_fall |=> sysm_pend_q)
      else $error("management edge lost");

   mgmt_lock_a: assert property (
      @(posedge core_clk) disable iff (srst)
      mgmt_enter_q |-> $past(instr_boundary) && !$past(locked_seq) &&
      sysmgmt_mode)
      else $error("management entry off boundary or inside lock");

   mgmt_nest_a: assert property (
      @(posedge core_clk) disable iff (srst)
      $past(sysmgmt_mode) && sysmgmt_mode |-> !mgmt_enter_q)
      else $error("management routine re-entered");

   active_pin_a: assert property (
      @(posedge core_clk) disable iff (srst)
      sysmgmt_active_n == !sysmgmt_mode)
      else $error("active output disagrees with mode");

   grant_cycle_a: assert property (
      @(posedge core_clk) disable iff (srst)
      (stopped_q && !$past(stopped_q)) |-> $past(cyc_type_q) ==
      CRI_CYC_HALTGNT && $past(bus_cycle_done))
      else $error("stopped without halt-grant cycle");

   busreq_out_a: assert property (
      @(posedge core_clk) disable iff (rst_any)
      core_bus_req |=> bus_request_out)
      else $error("bus request output missed internal request");

   base_keep_a: assert property (@(posedge core_clk)
      (soft_s && !hard_s && !srst) |=> $stable(sysmgmt_base_reg))
      else $error("soft reset altered base register");
endmodule
`default_nettype wire

/* File: rtl/cri_pkg.sv */
// Constants and types of the reset, interrupt and system-management control
package cri_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      CRI_IDLE,
      CRI_INTA1,
      CRI_INTA2,
      CRI_MGMT,
      CRI_DRAIN,
      CRI_GRANT,
      CRI_STOP
   } cri_state_t;

   // Bus cycle kinds issued by this block
   typedef enum logic [1:0] {
      CRI_CYC_NONE,
      CRI_CYC_INTACK,
      CRI_CYC_HALTGNT
   } cri_cyc_t;

   localparam int CRI_SYNC_STAGES = 2;
   localparam int CRI_NIN = 6;
   // Input lane positions in the synchroniser vector
   localparam int CRI_LN_HARD = 0;
   localparam int CRI_LN_SOFT = 1;
   localparam int CRI_LN_MIRQ = 2;
   localparam int CRI_LN_NMI = 3;
   localparam int CRI_LN_SYSM_N = 4;
   localparam int CRI_LN_HALT_N = 5;
   // Idle levels of the lanes: active-low lanes idle high
   localparam logic [5:0] CRI_SYNC_RST = 6'h30;
   // Low cycles required before a non-maskable edge counts
   localparam int CRI_NMI_LOW_MIN = 4;
   localparam logic [2:0] CRI_NMI_LOW_MAX = 3'h4;
   // Power-on state of the system-management base register
   localparam logic [31:0] CRI_BASE_RST = 32'h0000_0000;
endpackage

/* File: rtl/cri_sync_if.sv */
// Carrier between the controller and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface cri_sync_if #(parameter int W = 6);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface
`default_nettype wire

/* File: rtl/cri_sync.sv */
// Multi-stage synchroniser for the asynchronous system inputs
`timescale 1ns/1ps
`default_nettype none
module cri_sync
   import cri_pkg::*;
#(
   parameter int W = 6,
   parameter int STAGES = 2,
   parameter logic [5:0] RST_VAL = 6'h30
) (
   input wire logic core_clk,
   input wire logic srst,
   cri_sync_if.dst sif
);
   // ***************************************************
   // Shift chain, first stage read only by the next one
   // ***************************************************
   logic [W-1:0] stage_q [STAGES];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_q[i] <= RST_VAL[W-1:0];
         end
      end else begin
         stage_q[0] <= sif.raw;
         for (int i = 1; i < STAGES; i++) begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   assign sif.synced = stage_q[STAGES-1];
endmodule
`default_nettype wire

/* File: sim/cri_chipset.sv */
// Chipset-side model that completes the bus cycles of the block
`timescale 1ns/1ps
`default_nettype none
module cri_chipset
   import cri_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] lat,
   input wire logic cyc_req_q,
   input wire cri_cyc_t cyc_type_q,
   input wire logic cyc_lock_q,
   output logic bus_cycle_done,
   output logic [7:0] ack_cnt,
   output logic [7:0] gnt_cnt
);
   logic [3:0] wait_q;
   // Each cycle ends after lat wait states, one-clock done pulse
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bus_cycle_done <= 1'b0;
         wait_q <= 4'h0;
         ack_cnt <= 8'h0;
         gnt_cnt <= 8'h0;
      end else if (cyc_req_q && !bus_cycle_done) begin
         if (wait_q == lat) begin
            bus_cycle_done <= 1'b1;
            wait_q <= 4'h0;
            if (cyc_type_q == CRI_CYC_INTACK && cyc_lock_q) begin
               ack_cnt <= ack_cnt + 8'h1;
            end
            if (cyc_type_q == CRI_CYC_HALTGNT) begin
               gnt_cnt <= gnt_cnt + 8'h1;
            end
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end else begin
         bus_cycle_done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb_cpu_reset_irq_sysmgmt_ctrl.sv */
// Self-checking bench of the reset, interrupt and management control
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_reset_irq_sysmgmt_ctrl;
   import cri_pkg::*;
   logic core_clk = 0, srst = 1, hard_reset_in = 0, soft_reset_in = 0;
   logic maskable_irq_in = 0, nmi_in = 0, sysmgmt_irq_n = 1;
   logic clock_halt_req_n = 1, instr_boundary = 0, locked_seq = 0;
   logic if_flag = 0, core_bus_req = 0, drain_empty = 1, bus_cycle_done;
   logic resume_instruction = 0, restore_last = 0, base_wr = 0;
   logic [31:0] base_wdata = 32'h0, sysmgmt_base_reg;
   logic core_reset_q, mirq_take_q, nmi_take_q, mgmt_enter_q, sysmgmt_mode;
   logic sysmgmt_active_n, cyc_req_q, cyc_lock_q, stopped_q, bus_request_out;
   cri_cyc_t cyc_type_q;
   logic [7:0] ack_cnt, gnt_cnt;
   logic [3:0] lat = 4'h3;
   int num_errors = 0, num_checks = 0, cyc = 0;
   wire [3:0] obs = {stopped_q, mirq_take_q, nmi_take_q, mgmt_enter_q};

   cri_ctrl i_cri_ctrl (.core_clk, .srst, .hard_reset_in, .soft_reset_in,
      .maskable_irq_in, .nmi_in, .sysmgmt_irq_n, .clock_halt_req_n,
      .instr_boundary, .locked_seq, .if_flag, .core_bus_req, .drain_empty,
      .bus_cycle_done, .resume_instruction, .restore_last, .base_wr,
      .base_wdata, .core_reset_q, .mirq_take_q, .nmi_take_q, .mgmt_enter_q,
      .sysmgmt_mode, .sysmgmt_active_n, .cyc_req_q, .cyc_type_q, .cyc_lock_q,
      .stopped_q, .bus_request_out, .sysmgmt_base_reg);
   cri_chipset i_cri_chipset (.core_clk, .srst, .lat, .cyc_req_q,
      .cyc_type_q, .cyc_lock_q, .bus_cycle_done, .ack_cnt, .gnt_cnt);

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         close_out;
      end
   end

   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bnd;
      instr_boundary <= 1'b1;
      tick(1);
      instr_boundary <= 1'b0;
   endtask
   task wait_for(input int idx);
      for (int k = 0; k < 60; k++) begin
         #2;
         if (obs[idx] === 1'b1) break;
         tick(1);
      end
      chk(obs[idx], 1);
   endtask
   task pulse_exit;
      resume_instruction <= 1'b1;
      restore_last <= 1'b1;
      tick(1);
      resume_instruction <= 1'b0;
      restore_last <= 1'b0;
      tick(3);
      #2 chk(sysmgmt_active_n, 1);
   endtask
   task close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task t_busreq;
      tick(1);
      core_bus_req <= 1'b1;
      tick(4);
      #2 chk(bus_request_out, 1);
      tick(1);
      core_bus_req <= 1'b0;
      tick(4);
      #2 chk(bus_request_out, 0);
      $display("test bus request done");
   endtask
   task t_maskable;
      tick(1);
      maskable_irq_in <= 1'b1;
      tick(4);
      bnd;
      tick(6);
      #2 chk(cyc_req_q, 0);
      tick(1);
      if_flag <= 1'b1;
      tick(4);
      bnd;
      tick(1);
      #2 chk({cyc_req_q, cyc_type_q, cyc_lock_q}, 4'hb);
      wait_for(2);
      chk(ack_cnt, 2);
      tick(1);
      maskable_irq_in <= 1'b0;
      if_flag <= 1'b0;
      $display("test maskable done");
   endtask
   task t_nmi;
      tick(1);
      nmi_in <= 1'b1;
      tick(4);
      bnd;
      wait_for(1);
      tick(1);
      nmi_in <= 1'b0;
      // A rise after only two low clocks must not count
      tick(2);
      nmi_in <= 1'b1;
      tick(4);
      bnd;
      #2 chk(nmi_take_q, 0);
      tick(1);
      nmi_in <= 1'b0;
      $display("test nmi done");
   endtask
   task t_smi;
      tick(1);
      sysmgmt_irq_n <= 1'b0;
      locked_seq <= 1'b1;
      tick(4);
      bnd;
      tick(3);
      #2 chk(sysmgmt_active_n, 1);
      tick(1);
      locked_seq <= 1'b0;
      tick(3);
      bnd;
      wait_for(0);
      chk(sysmgmt_active_n, 0);
      tick(1);
      sysmgmt_irq_n <= 1'b1;
      tick(4);
      sysmgmt_irq_n <= 1'b0;
      tick(4);
      bnd;
      #2 chk(mgmt_enter_q, 0);
      tick(3);
      #2 chk(sysmgmt_mode, 1);
      tick(1);
      sysmgmt_irq_n <= 1'b1;
      pulse_exit;
      tick(1);
      bnd;
      wait_for(0);
      tick(1);
      pulse_exit;
      $display("test management done");
   endtask
   task t_stop;
      tick(1);
      lat <= 4'h0;
      drain_empty <= 1'b0;
      clock_halt_req_n <= 1'b0;
      tick(4);
      bnd;
      tick(4);
      #2 chk(cyc_req_q, 0);
      tick(1);
      drain_empty <= 1'b1;
      wait_for(3);
      chk(gnt_cnt, 1);
      tick(1);
      clock_halt_req_n <= 1'b1;
      tick(5);
      #2 chk(stopped_q, 0);
      $display("test stop done");
   endtask
   task t_resets;
      tick(1);
      base_wdata <= 32'h0012_0000;
      base_wr <= 1'b1;
      tick(1);
      base_wr <= 1'b0;
      tick(2);
      soft_reset_in <= 1'b1;
      tick(5);
      #2 chk(core_reset_q, 1);
      tick(1);
      base_wdata <= 32'h0045_0000;
      base_wr <= 1'b1;
      tick(1);
      base_wr <= 1'b0;
      tick(8);
      soft_reset_in <= 1'b0;
      tick(6);
      #2 chk(core_reset_q, 0);
      chk(sysmgmt_base_reg, 32'h0012_0000);
      tick(1);
      hard_reset_in <= 1'b1;
      tick(15);
      hard_reset_in <= 1'b0;
      tick(6);
      #2 chk(sysmgmt_base_reg, CRI_BASE_RST);
      $display("test resets done");
   endtask

   initial begin
      tick(9);
      #2 chk(core_reset_q, 1);
      chk(sysmgmt_active_n, 1);
      chk(sysmgmt_base_reg, CRI_BASE_RST);
      tick(1);
      // Power-up hold scaled down: the block itself counts no time
      srst <= 1'b0;
      tick(8);
      t_busreq;
      t_maskable;
      t_nmi;
      t_smi;
      t_stop;
      t_resets;
      close_out;
   end
endmodule
`default_nettype wire
